// >>> src/isrb_slave.sv
// isrb_slave: two-wire slave port with register pointer and ring buffer readout.
// assumes: scl and sda samples are synchronous to clk_in and far slower than it;
// register read data and sample data follow their address within two clocks.
`default_nettype none
// Summary of operation
// - ack address and data bytes by pulling data low in the ninth clock
// - when sending, wait for the master's ack or nack of each byte
// - during software reboot the slave address gets a nack
// - first written byte after address loads the register pointer
// - stop alone leaves the register pointer unchanged
// - later written bytes go to the pointed register if the code is valid
// - pointer increments after each acked written data byte
// - command code outside 0x00 to 0x74 and 0x80 to 0x87 gets a nack
// - pointer wraps to 0x00 after the highest register
// - read returns eight bits then the pointer increments
// - 0x80 to 0x87 are buffer channels, anything else outside gets nack
// - a read after loading a buffer base address starts buffer readout
// - during readout the pointer does not auto-increment
// - master nack ends readout; a new read with the pointer unchanged restarts it at slot 0
// - in 8-bit mode one byte carries one sample
// - in 10-bit mode high byte first, then two lsbs right aligned
// - order: samples 1 up to 49, then the oldest sample 0, fifty total
module isrb_slave
  import isrb_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A, // arbitrary default
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic reboot_busy_in,
  input wire logic mode10_in,
  output logic [6:0] reg_addr_out,
  input wire logic [7:0] reg_rdata_in,
  output logic reg_wr_valid_out,
  input wire logic reg_wr_ready_in,
  output isrb_wr_type reg_wr_out,
  output isrb_smp_req_type smp_req_out,
  input wire logic [9:0] smp_data_in,
  output logic readout_active_out
);
  isrb_state_type state;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] ptr;
  logic first_byte;
  logic master_ack;
  logic rb_active;
  logic [5:0] rb_slot;
  logic rb_half;
  logic [7:0] tx_byte;
  logic push;
  isrb_wr_type push_item;
  logic fifo_in_ready;
  logic accept_cmd;
  logic accept_data;
  logic addr_hit;
  logic addr_done;
  logic cmd_done;
  logic ack_rise;
  logic ack_fall;

  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign start_cond = scl_in && scl_q && sda_q && !sda_in;
  assign stop_cond = scl_in && scl_q && !sda_q && sda_in;

  // a written byte that would not fit is refused, the fifo never drops one
  assign accept_cmd = isrb_is_cfg(rx_shift) || isrb_is_buf(rx_shift);
  assign accept_data = isrb_is_cfg(ptr) && fifo_in_ready;
  assign addr_hit = (rx_shift[7:1] == SLAVE_ADDR);

  // byte-level strobes; start and stop mask the three fall strobes, so a stop alone moves nothing
  assign addr_done = !start_cond && !stop_cond && scl_fall && state == ST_ADDR
                     && bit_cnt == BITS_PER_BYTE;
  assign cmd_done = !start_cond && !stop_cond && scl_fall && state == ST_WR_BYTE
                    && bit_cnt == BITS_PER_BYTE && first_byte;
  assign ack_rise = scl_rise && state == ST_RD_ACK;
  assign ack_fall = !start_cond && !stop_cond && scl_fall && state == ST_RD_ACK;

  // byte presented to the master for the current read
  always_comb begin
    tx_byte = reg_rdata_in;
    if (rb_active) begin
      if (mode10_in && rb_half) begin
        tx_byte = {6'h00, smp_data_in[LSB_FIELD_W-1:0]};
      end else begin
        tx_byte = smp_data_in[9:2];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // bus-level protocol engine
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      rx_shift <= '0;
      tx_shift <= '0;
      sda_oe_out <= 1'b0;
      first_byte <= 1'b0;
      master_ack <= 1'b0;
    end else if (start_cond) begin
      state <= ST_ADDR;
      bit_cnt <= '0;
      sda_oe_out <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_oe_out <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            rx_shift <= {rx_shift[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            if (addr_hit && !reboot_busy_in) begin
              sda_oe_out <= 1'b1;
              state <= ST_ADDR_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt <= '0;
            if (rx_shift[0]) begin
              tx_shift <= tx_byte;
              sda_oe_out <= !tx_byte[7];
              state <= ST_RD_BYTE;
            end else begin
              sda_oe_out <= 1'b0;
              first_byte <= 1'b1;
              state <= ST_WR_BYTE;
            end
          end
        end
        ST_WR_BYTE: begin
          if (scl_rise) begin
            rx_shift <= {rx_shift[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            if (first_byte ? accept_cmd : accept_data) begin
              sda_oe_out <= 1'b1;
              state <= ST_WR_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            first_byte <= 1'b0;
            bit_cnt <= '0;
            state <= ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
              sda_oe_out <= 1'b0;
              state <= ST_RD_ACK;
            end else begin
              tx_shift <= {tx_shift[6:0], 1'b0};
              sda_oe_out <= !tx_shift[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            master_ack <= !sda_in;
          end else if (scl_fall) begin
            bit_cnt <= '0;
            if (master_ack) begin
              tx_shift <= tx_byte;
              sda_oe_out <= !tx_byte[7];
              state <= ST_RD_BYTE;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // register pointer; only byte-level events move it, never stop alone
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ptr <= PTR_RESET;
    end else if (!start_cond && !stop_cond && scl_fall) begin
      if (state == ST_WR_BYTE && bit_cnt == BITS_PER_BYTE) begin
        if (first_byte && accept_cmd) begin
          ptr <= rx_shift;
        end else if (!first_byte && accept_data) begin
          ptr <= isrb_ptr_inc(ptr);
        end
      end else if (state == ST_RD_BYTE && bit_cnt == BITS_PER_BYTE - 4'h1) begin
        if (!rb_active) begin
          ptr <= isrb_ptr_inc(ptr);
        end
      end
    end
  end

  // ring buffer readout sequencing; a read arms it at its address byte, so the
  // first sample is fetched well before its first bit is loaded for sending
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rb_active <= 1'b0;
      rb_slot <= '0;
      rb_half <= 1'b0;
    end else if (cmd_done && accept_cmd) begin
      rb_active <= 1'b0; // any new pointer ends a readout; the next read re-arms
      rb_slot <= '0;
      rb_half <= 1'b0;
    end else if (addr_done && addr_hit && !reboot_busy_in && rx_shift[0] && !rb_active
                 && isrb_is_buf(ptr)) begin
      rb_active <= 1'b1;
      rb_slot <= '0;
      rb_half <= 1'b0;
    end else if (ack_fall && rb_active && !master_ack) begin
      rb_active <= 1'b0;
    end else if (ack_rise && rb_active && !sda_in) begin
      // advance on the ack itself: the next byte is loaded at the following fall
      if (mode10_in && !rb_half) begin
        rb_half <= 1'b1;
      end else begin
        rb_half <= 1'b0;
        rb_slot <= (rb_slot == LAST_SLOT) ? 6'h00 : rb_slot + 6'h01;
      end
    end
  end

  // addresses out to the register bank and the sample store
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_addr_out <= '0;
      smp_req_out <= '0;
      readout_active_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      reg_addr_out <= ptr[6:0];
      smp_req_out.chan <= ptr[2:0];
      smp_req_out.idx <= isrb_slot_idx(rb_slot);
      readout_active_out <= rb_active;
      sda_out <= 1'b0;
    end
  end

  // accepted data bytes queue for the register bank
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      push <= 1'b0;
      push_item <= '0;
    end else begin
      push <= !start_cond && !stop_cond && scl_fall && state == ST_WR_BYTE
              && bit_cnt == BITS_PER_BYTE && !first_byte && accept_data;
      push_item.addr <= ptr[6:0];
      push_item.data <= rx_shift;
    end
  end

  isrb_fifo #(
    .WIDTH($bits(isrb_wr_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_item),
    .out_valid_out(reg_wr_valid_out),
    .out_ready_in(reg_wr_ready_in),
    .out_data_out(reg_wr_out)
  );
endmodule
`default_nettype wire

// >>> src/isrb_pkg.sv
// isrb_pkg: shared constants and types for the two-wire slave readout block.
// assumes: users import isrb_pkg::* in module headers.
`default_nettype none
package isrb_pkg;
  localparam logic [7:0] CFG_FIRST = 8'h00;
  localparam logic [7:0] CFG_LAST = 8'h74;
  localparam logic [7:0] BUF_FIRST = 8'h80;
  localparam logic [7:0] BUF_LAST = 8'h87;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int SAMPLE_COUNT = 50;
  localparam logic [5:0] LAST_SLOT = 6'h31;
  localparam logic [5:0] OLDEST_IDX = 6'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int LSB_FIELD_W = 2;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK
  } isrb_state_type;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } isrb_wr_type;

  typedef struct packed {
    logic [2:0] chan;
    logic [5:0] idx;
  } isrb_smp_req_type;

  function automatic logic isrb_is_cfg(input logic [7:0] p);
    return (p >= CFG_FIRST) && (p <= CFG_LAST);
  endfunction

  function automatic logic isrb_is_buf(input logic [7:0] p);
    return (p >= BUF_FIRST) && (p <= BUF_LAST);
  endfunction

  function automatic logic [7:0] isrb_ptr_inc(input logic [7:0] p);
    return (p >= CFG_LAST) ? CFG_FIRST : p + 8'h01;
  endfunction

  // readout slot k holds chronological sample k+1, the last slot the oldest
  function automatic logic [5:0] isrb_slot_idx(input logic [5:0] k);
    return (k == LAST_SLOT) ? OLDEST_IDX : k + 6'h01;
  endfunction
endpackage
`default_nettype wire

// >>> src/isrb_fifo.sv
// isrb_fifo: small shift fifo, head word and valid come straight from flops.
// assumes: one clock, synchronous active-high reset.
`default_nettype none
module isrb_fifo
  import isrb_pkg::*;
#(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  assign in_ready_out = (count != CW'(DEPTH));
  assign pop = out_valid_out && out_ready_in;
  assign push = in_valid_in && in_ready_out;
  assign out_data_out = mem[0];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count <= '0;
      out_valid_out <= 1'b0;
    end else begin
      count <= next_count;
      out_valid_out <= (next_count != '0);
    end
  end

  // shift on pop; a push lands just above the words that remain
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && i < DEPTH - 1) begin
        mem[i] <= mem[i+1];
      end
      if (push && CW'(i) == (pop ? count - CW'(1) : count)) begin
        mem[i] <= in_data_in;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/isrb_master.sv
// isrb_master: behavioural two-wire bus master, drives clock and open-drain data.
// assumes: sda_in is the resolved wire with a pull-up; outputs change at falling clk.
`default_nettype none
module isrb_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int hp = 4; // clocks per half bit; raised to act as a slow master
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // also serves as repeated start
  task automatic start;
    tick(1);
    sda_out = 1'b1;
    tick(hp);
    scl_out = 1'b1;
    tick(hp);
    sda_out = 1'b0;
    tick(hp);
    scl_out = 1'b0;
  endtask
  task automatic stop;
    tick(1);
    sda_out = 1'b0;
    tick(hp);
    scl_out = 1'b1;
    tick(hp);
    sda_out = 1'b1;
    tick(hp);
  endtask
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_out = b;
    tick(hp);
    scl_out = 1'b1;
    tick(hp);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// >>> verif/isrb_slave_sva.sv
// isrb_slave_sva: port-level assertions for the two-wire slave readout block.
// assumes: bound into every isrb_slave; single clock domain.
`default_nettype none
module isrb_slave_sva
  import isrb_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [6:0] reg_addr_out,
  input wire logic reg_wr_valid_out,
  input wire logic reg_wr_ready_in,
  input wire isrb_wr_type reg_wr_out,
  input wire isrb_smp_req_type smp_req_out,
  input wire logic readout_active_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic [5:0] idx;
  assign idx = smp_req_out.idx;
  a_sda_zero: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  a_reset_quiet: assert property ($past(srst_in) |-> !sda_oe_out && !reg_wr_valid_out
    && !readout_active_out && reg_addr_out == 7'h00)
    else $error("outputs not cleared by reset");
  a_oe_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("data drive changed while clock high");
  a_ro_base_addr: assert property ($past(readout_active_out) && readout_active_out
    |-> reg_addr_out[6:3] == 4'h0)
    else $error("readout outside buffer channels");
  a_ro_no_inc: assert property (readout_active_out [*3] |-> $stable(reg_addr_out))
    else $error("pointer moved during readout");
  a_idx_range: assert property (idx <= LAST_SLOT)
    else $error("sample index out of range");
  a_idx_order: assert property (readout_active_out && $past(readout_active_out)
    && $changed(idx) |-> idx == $past(idx) + 6'h01 || idx == 6'h01
    || ($past(idx) == 6'h31 && idx == 6'h00))
    else $error("sample order broken");
  a_wr_hold: assert property (reg_wr_valid_out && !reg_wr_ready_in
    |=> reg_wr_valid_out && $stable(reg_wr_out))
    else $error("queued write lost or changed");
  a_wr_addr_cfg: assert property (reg_wr_valid_out |-> reg_wr_out.addr <= 7'h74)
    else $error("write outside register range");
endmodule
bind isrb_slave isrb_slave_sva u_sva (.clk_in, .srst_in, .scl_in, .sda_out, .sda_oe_out,
  .reg_addr_out, .reg_wr_valid_out, .reg_wr_ready_in, .reg_wr_out, .smp_req_out,
  .readout_active_out);
`default_nettype wire

// >>> verif/isrb_slave_tb_top.sv
// isrb_slave_tb_top: self-checking bench for the two-wire slave readout block.
// assumes: isrb_master as bus partner; register bank and sample store modelled here.
`default_nettype none
module isrb_slave_tb_top
  import isrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] SA = 7'h2A; // arbitrary slave address
  typedef struct {logic [7:0] code; logic ack;} isrb_row_type;
  isrb_row_type rows[7] = '{'{8'h00, 1'b1}, '{8'h74, 1'b1}, '{8'h75, 1'b0}, '{8'h88, 1'b0},
    '{8'hFF, 1'b0}, '{8'h10, 1'b1}, '{8'h7F, 1'b0}};
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic busy = 1'b0;
  logic mode10 = 1'b0;
  logic ready = 1'b1;
  logic [7:0] rd = 8'h00;
  logic [9:0] smp = 10'h000;
  logic scl, m_sda, sda_w, s_sda, s_oe, ro, wv, ack;
  logic [6:0] ra;
  logic [7:0] d;
  logic [9:0] e10;
  isrb_wr_type wr;
  isrb_smp_req_type sq;
  isrb_wr_type wq[$];
  int fails = 0;
  int checks = 0;
  assign sda_w = m_sda & (s_oe ? s_sda : 1'b1);
  isrb_slave #(.SLAVE_ADDR(SA), .FIFO_DEPTH(4)) uut (.clk_in(clk_in), .srst_in(srst_in),
    .scl_in(scl), .sda_in(sda_w), .sda_out(s_sda), .sda_oe_out(s_oe), .reboot_busy_in(busy),
    .mode10_in(mode10), .reg_addr_out(ra), .reg_rdata_in(rd), .reg_wr_valid_out(wv),
    .reg_wr_ready_in(ready), .reg_wr_out(wr), .smp_req_out(sq), .smp_data_in(smp),
    .readout_active_out(ro));
  isrb_master mst (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));
  initial forever #4 clk_in = ~clk_in;
  always @(negedge clk_in) begin
    rd <= {1'b0, ra} ^ 8'hA5;
    smp <= {sq.chan, 1'b0, sq.idx};
  end
  always @(posedge clk_in) if (wv && ready) wq.push_back(wr);
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic addr(input logic [6:0] a, input logic rw);
    mst.start();
    mst.put({a, rw}, ack);
  endtask
  task automatic point(input logic [7:0] p);
    addr(SA, 1'b0);
    mst.put(p, ack);
    mst.stop();
  endtask
  // readout slot k: chronological k+1, the last slot the oldest
  function automatic logic [9:0] sample(input logic [2:0] c, input int k);
    return {c, 1'b0, 6'(k == 49 ? 0 : k + 1)};
  endfunction
  initial begin
    repeat (60000) @(posedge clk_in);
    fails++;
    end_sim();
  end
  initial begin
    repeat (8) @(negedge clk_in);
    srst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("oe", s_oe, 0);
    chk("pointer", ra, 0);
    foreach (rows[i]) begin
      point(rows[i].code);
      chk("code ack", ack, rows[i].ack);
    end
    addr(SA, 1'b1);
    mst.get(1'b1, d);
    mst.stop();
    chk("kept ptr", d, 8'h10 ^ 8'hA5);
    point(8'h73);
    addr(SA, 1'b1);
    for (int i = 0; i < 3; i++) begin
      mst.get(i == 2, d);
      chk("read", d, {1'b0, 7'(i == 2 ? 0 : 8'h73 + i)} ^ 8'hA5);
    end
    mst.stop();
    busy = 1'b1;
    addr(SA, 1'b0);
    chk("busy ack", ack, 0);
    mst.stop();
    busy = 1'b0;
    addr(SA ^ 7'h01, 1'b0);
    chk("other addr", ack, 0);
    mst.stop();
    addr(SA, 1'b0); // retry after refusal
    chk("retry ack", ack, 1);
    mst.stop();
    // hold writes in the fifo so the fifth data byte is refused
    wq.delete();
    ready = 1'b0;
    addr(SA, 1'b0);
    mst.put(8'h73, ack);
    for (int i = 0; i < 5; i++) begin
      mst.put(8'hD0 + 8'(i), ack);
      chk("fifo ack", ack, i < 4);
    end
    mst.stop();
    chk("wr held", wv, 1);
    ready = 1'b1;
    for (int n = 0; wv !== 1'b0; n++) begin
      if (n > 50) begin
        fails++;
        end_sim();
      end
      @(negedge clk_in);
    end
    chk("wr count", wq.size(), 4);
    foreach (wq[i]) chk("wr word", wq[i], {7'(i < 2 ? 8'h73 + i : i - 2), 8'hD0 + 8'(i)});
    mst.hp = 9;
    point(8'h80);
    chk("buf ack", ack, 1);
    addr(SA, 1'b1);
    chk("ro on", ro, 1);
    for (int i = 0; i < 51; i++) begin
      mst.get(i == 50, d);
      chk("smp8", d, sample(3'h0, i % 50) >> 2);
    end
    mst.stop();
    chk("base", ra, 7'h00);
    chk("ro off", ro, 0);
    addr(SA, 1'b1); // pointer still at the base: a fresh read restarts the buffer
    chk("rearm ack", ack, 1);
    mst.get(1'b1, d);
    mst.stop();
    chk("rearm", d, sample(3'h0, 0) >> 2);
    mst.hp = 4;
    mode10 = 1'b1;
    point(8'h87);
    chk("buf ack", ack, 1);
    addr(SA, 1'b1);
    for (int i = 0; i < 4; i++) begin
      e10 = sample(3'h7, i / 2);
      mst.get(i == 3, d);
      chk("smp10", d, (i % 2) ? e10[1:0] : e10[9:2]);
    end
    mst.stop();
    end_sim();
  end
endmodule
`default_nettype wire
